// [design/timer16_map.svh]
`ifndef TIMER16_MAP_SVH
`define TIMER16_MAP_SVH

// register byte offsets on the bus
`define OFF_CONTROL    8'h00
`define OFF_COUNT_LOW  8'h04
`define OFF_COUNT_HIGH 8'h08
`define OFF_STATUS     8'h0C
`define OFF_PORT       8'h10

// reset values and the all-ones count at which the counter wraps
`define CONTROL_RESET  8'h00
`define PORT_RESET     4'h0
`define COUNT_RESET    16'h0000
`define COUNT_ALL_ONES 16'hFFFF

// control bits software may write; bit 6 is read-only status
`define CONTROL_WMASK  8'hBF

// status register fields
`define STAT_FLAG_BIT  0
`define STAT_IE_BIT    1

// port register fields
`define PORT_OUT_LSB   0
`define PORT_DIR_LSB   2

// instruction clock is the system clock divided by this
`define INSTR_DIV      4

`endif

// [design/timer16_pkg.sv]
package timer16_pkg;

  typedef struct packed {
    logic       wide_access_enable;
    logic       sysclk_from_lp_osc;
    logic [1:0] prescale_select;
    logic       lp_osc_enable;
    logic       no_sync_select;
    logic       source_select;
    logic       count_on;
  } timer_control_t;

  typedef struct packed {
    logic [7:0] addr;
    logic       write;
  } bus_req_t;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_WRITE,
    BUS_READ
  } bus_phase_t;

endpackage

// [design/sync2.sv]
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule // sync2

// [design/prescaler.sv]
module prescaler (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       clear,
  input  wire logic       tick_in,
  input  wire logic [1:0] select,
  output logic            tick_out
);

  logic [2:0] cnt_reg;
  logic [2:0] mask;

  // 00 -> 1:1, 01 -> 1:2, 10 -> 1:4, 11 -> 1:8
  assign mask     = (select == 2'h3) ? 3'h7 : (select == 2'h2) ? 3'h3 :
                    (select == 2'h1) ? 3'h1 : 3'h0;
  assign tick_out = tick_in && ((cnt_reg & mask) == mask);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= 3'h0;
    end else if (clear) begin
      cnt_reg <= 3'h0;
    end else if (tick_in) begin
      cnt_reg <= cnt_reg + 3'h1;
    end
  end

  a_div_by_four : assert property (@(posedge hclk) disable iff (!hresetn)
    (select == 2'h2 && tick_out) |-> cnt_reg[1:0] == 2'h3)
    else $error("divide-by-4 output at wrong prescale count");

  a_div_by_one : assert property (@(posedge hclk) disable iff (!hresetn)
    (select == 2'h0) |-> (tick_out == tick_in))
    else $error("divide-by-1 prescale dropped a tick");

endmodule // prescaler

// [design/timer16_top.sv]
// What this block does
// - sixteen-bit counter, runs as timer on internal clock or counter of edges.
// - counter advances only while control bit 0 is set, else holds.
// - internal source increments once per instruction cycle, system clock over four.
// - external source counts rising edges of pin, or oscillator when enabled.
// - control bit 3 enables the low-power oscillator, clear shuts it off.
// - read-only bit 6 shows system clock comes from this oscillator.
// - oscillator enabled disables port logic on its pins, which read zero.
// - control bit 7 selects sixteen-bit access, clear gives two byte accesses.
// - in wide mode the high-byte address reaches a buffer, not the counter.
// - wide mode low-byte read copies live upper byte into the buffer.
// - wide high write fills buffer only; low write loads all sixteen bits.
// - wide mode gives no direct path to the live upper byte.
// - low-byte writes clear the prescaler, high-byte writes do not.
// - counter wraps all ones to zero, setting overflow flag; interrupt only when enabled.
// - compare trigger resets counter unless async counter; a write wins.
// - counter mode needs a falling edge before the first counted rising edge.
//
// The implementer's own choices: the AHB-Lite interface to the registers and the placing of the registers.
module timer16_top
  import timer16_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        ext_count_pin,
  input  wire logic        lp_osc_clk,
  input  wire logic        sysclk_from_lp_osc,
  input  wire logic        xtal_in_pin,
  input  wire logic        xtal_out_pin,
  input  wire logic        compare_trigger,
  output logic             lp_osc_enable,
  output logic             overflow_irq,
  output logic      [1:0]  xtal_pins_out,
  output logic      [1:0]  xtal_pins_oe
);

`include "timer16_map.svh"

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  ////////////////////////////////////////////////////////////////////////////
  // bus slave

  function automatic logic hit(bus_req_t r, logic [7:0] off);
    return r.addr == off;
  endfunction

  bus_phase_t     phase_reg;
  bus_phase_t     phase_next;
  bus_req_t       req_reg;
  logic           addr_ok;
  logic           is_wr;
  logic           is_rd;
  logic           wr_ctrl;
  logic           wr_low;
  logic           wr_high;
  logic           wr_stat;
  logic           wr_port;
  logic           rd_low;
  logic [7:0]     wbyte;
  logic [7:0]     rbyte;

  // reads take one wait state so a write just committed is seen
  assign addr_ok    = hsel && htrans[1] && hready;
  assign phase_next = !addr_ok ? BUS_IDLE : (hwrite ? BUS_WRITE : BUS_READ);
  assign is_wr      = (phase_reg == BUS_WRITE);
  assign is_rd      = (phase_reg == BUS_READ);
  assign wbyte      = hwdata[7:0];
  assign wr_ctrl    = is_wr && hit(req_reg, `OFF_CONTROL);
  assign wr_low     = is_wr && hit(req_reg, `OFF_COUNT_LOW);
  assign wr_high    = is_wr && hit(req_reg, `OFF_COUNT_HIGH);
  assign wr_stat    = is_wr && hit(req_reg, `OFF_STATUS);
  assign wr_port    = is_wr && hit(req_reg, `OFF_PORT);
  assign rd_low     = is_rd && hit(req_reg, `OFF_COUNT_LOW);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_reg <= BUS_IDLE;
      req_reg   <= '0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
    end else begin
      phase_reg <= phase_next;
      hreadyout <= !(addr_ok && !hwrite);
      hresp     <= 1'b0;
      if (addr_ok) begin
        req_reg <= '{addr: haddr[7:0], write: hwrite};
      end
      if (is_rd) begin
        hrdata <= {24'h00_0000, rbyte};
      end
    end
  end

  sequence read_wait_seq;
    !hreadyout ##1 hreadyout;
  endsequence

  a_read_one_wait : assert property (
    (addr_ok && !hwrite) |=> read_wait_seq)
    else $error("read did not complete after exactly one wait state");

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [4:0] pins_s;
  logic       ext_pin_s;
  logic       lp_osc_s;
  logic       sysrun_s;
  logic [1:0] xtal_s;

  sync2 #(.W(5)) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       ({xtal_out_pin, xtal_in_pin, sysclk_from_lp_osc, lp_osc_clk,
                ext_count_pin}),
    .q       (pins_s)
  );

  assign ext_pin_s = pins_s[0];
  assign lp_osc_s  = pins_s[1];
  assign sysrun_s  = pins_s[2];
  assign xtal_s    = pins_s[4:3];

  ////////////////////////////////////////////////////////////////////////////
  // control and port registers

  timer_control_t ctrl_reg;
  timer_control_t ctrl_next;
  logic [3:0]     port_reg;
  logic           prev_on_reg;

  assign ctrl_next = wr_ctrl ? timer_control_t'((wbyte & `CONTROL_WMASK) |
                                                (ctrl_reg & ~`CONTROL_WMASK))
                             : ctrl_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg      <= timer_control_t'(`CONTROL_RESET);
      port_reg      <= `PORT_RESET;
      prev_on_reg   <= 1'b0;
      lp_osc_enable <= 1'b0;
      xtal_pins_out <= 2'h0;
      xtal_pins_oe  <= 2'h0;
    end else begin
      ctrl_reg                    <= ctrl_next;
      ctrl_reg.sysclk_from_lp_osc <= sysrun_s;
      prev_on_reg                 <= ctrl_reg.count_on;
      lp_osc_enable               <= ctrl_reg.lp_osc_enable;
      if (wr_port) begin
        port_reg <= wbyte[3:0];
      end
      // oscillator owns the pins: direction ignored, drivers off
      xtal_pins_oe  <= ctrl_reg.lp_osc_enable ? 2'h0
                     : port_reg[`PORT_DIR_LSB +: 2];
      xtal_pins_out <= ctrl_reg.lp_osc_enable ? 2'h0
                     : port_reg[`PORT_OUT_LSB +: 2];
    end
  end

  a_pins_released : assert property (
    ctrl_reg.lp_osc_enable |=> (xtal_pins_oe == 2'h0))
    else $error("oscillator pins still driven while oscillator enabled");

  ////////////////////////////////////////////////////////////////////////////
  // count source, edge detect and prescale

  logic [1:0] quarter_reg;
  logic       int_tick;
  logic       ext_lvl;
  logic       ext_prev_reg;
  logic       rise;
  logic       fall;
  logic       armed_reg;
  logic       src_tick;
  logic       pre_in;
  logic       inc;
  logic       async_ext;

  assign int_tick  = (quarter_reg == 2'(`INSTR_DIV - 1));
  assign ext_lvl   = ctrl_reg.lp_osc_enable ? lp_osc_s : ext_pin_s;
  assign rise      = ext_lvl && !ext_prev_reg;
  assign fall      = !ext_lvl && ext_prev_reg;
  assign src_tick  = ctrl_reg.source_select ? (rise && armed_reg) : int_tick;
  assign pre_in    = ctrl_reg.count_on && src_tick;
  // no_sync only matters for the external source
  assign async_ext = ctrl_reg.source_select && ctrl_reg.no_sync_select;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      quarter_reg  <= 2'h0;
      ext_prev_reg <= 1'b0;
      armed_reg    <= 1'b0;
    end else begin
      quarter_reg  <= quarter_reg + 2'h1;
      ext_prev_reg <= ext_lvl;
      // a falling edge that coincides with a disarm still arms
      if (fall) begin
        armed_reg <= 1'b1;
      end else if ((ctrl_reg.count_on && !prev_on_reg) || wr_low || wr_high) begin
        armed_reg <= 1'b0;
      end
    end
  end

  prescaler u_presc (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .clear    (wr_low),
    .tick_in  (pre_in),
    .select   (ctrl_reg.prescale_select),
    .tick_out (inc)
  );

  a_arm_first : assert property (
    (ctrl_reg.source_select && rise && !armed_reg) |-> !pre_in)
    else $error("counted a rising edge before any falling edge");

  a_int_rate : assert property (
    (inc && !ctrl_reg.source_select) |-> (quarter_reg == 2'h3))
    else $error("internal tick not on instruction cycle boundary");

  ////////////////////////////////////////////////////////////////////////////
  // counter, buffer, overflow

  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic [7:0]  buf_reg;
  logic        trig_ok;
  logic        any_wr;
  logic        ovf_set;
  logic        flag_reg;
  logic        ie_reg;
  logic        flag_clr;
  logic        wide;

  assign wide     = ctrl_reg.wide_access_enable;
  // async counter cannot be reset reliably by the compare unit
  assign trig_ok  = compare_trigger && !async_ext;
  assign any_wr   = wr_low || (wr_high && !wide);
  assign ovf_set  = inc && (count_reg == `COUNT_ALL_ONES) && !any_wr && !trig_ok;
  assign flag_clr = wr_stat && wbyte[`STAT_FLAG_BIT];

  // write beats trigger, trigger beats increment
  assign count_next = wr_low ? {(wide ? buf_reg : count_reg[15:8]), wbyte}
                    : (wr_high && !wide) ? {wbyte, count_reg[7:0]}
                    : trig_ok ? `COUNT_RESET
                    : inc ? count_reg + 16'h0001
                    : count_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_reg    <= `COUNT_RESET;
      buf_reg      <= 8'h00;
      flag_reg     <= 1'b0;
      ie_reg       <= 1'b0;
      overflow_irq <= 1'b0;
    end else begin
      count_reg <= count_next;
      if (wr_high && wide) begin
        buf_reg <= wbyte;
      end else if (rd_low && wide) begin
        buf_reg <= count_reg[15:8];
      end
      flag_reg     <= ovf_set || (flag_reg && !flag_clr);
      if (wr_stat) begin
        ie_reg <= wbyte[`STAT_IE_BIT];
      end
      overflow_irq <= flag_reg && ie_reg;
    end
  end

  // read data: high address shows the buffer in wide mode
  assign rbyte = hit(req_reg, `OFF_CONTROL)    ? ctrl_reg
               : hit(req_reg, `OFF_COUNT_LOW)  ? count_reg[7:0]
               : hit(req_reg, `OFF_COUNT_HIGH) ? (wide ? buf_reg : count_reg[15:8])
               : hit(req_reg, `OFF_STATUS)     ? {6'h00, ie_reg, flag_reg}
               : hit(req_reg, `OFF_PORT)       ? {2'h0,
                   (ctrl_reg.lp_osc_enable ? 2'h0 : xtal_s), port_reg}
               : 8'h00;

  a_hold_when_off : assert property (
    (!ctrl_reg.count_on && !any_wr && !trig_ok) |=> $stable(count_reg))
    else $error("counter moved while switched off");

  a_wrap_flag : assert property (
    (inc && count_reg == `COUNT_ALL_ONES && !any_wr && !trig_ok)
      |=> (count_reg == `COUNT_RESET) && flag_reg)
    else $error("wrap did not clear counter and set overflow flag");

  a_wide_low_write : assert property (
    (wr_low && wide) |=> count_reg == {$past(buf_reg), $past(hwdata[7:0])})
    else $error("wide low write did not load all sixteen bits");

  a_high_buf_only : assert property (
    (wr_high && wide) |=> buf_reg == $past(hwdata[7:0]))
    else $error("wide high write did not land in the buffer");

  a_low_read_latch : assert property (
    (rd_low && wide)
      |=> (buf_reg == $past(count_reg[15:8])) && (hrdata[7:0] == $past(count_reg[7:0])))
    else $error("low read did not snapshot upper byte");

  a_trig_reset : assert property (
    (trig_ok && !any_wr) |=> count_reg == `COUNT_RESET)
    else $error("compare trigger did not reset counter");

  a_write_wins : assert property (
    (wr_low && !wide && trig_ok) |=> count_reg[7:0] == $past(hwdata[7:0]))
    else $error("trigger overrode a coincident write");

endmodule // timer16_top

// [bench/timer16_with_buffered_access_tb_top.sv]
`include "timer16_map.svh"
module timer16_with_buffered_access_tb_top
  import timer16_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic        hwrite;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        ext_pin;
  logic        lp_clk;
  logic        sys_lp;
  logic        xin;
  logic        xout;
  logic        trig;
  logic        osc_en;
  logic        irq;
  logic [1:0]  pins_out;
  logic [1:0]  pins_oe;
  logic [7:0]  rd;
  logic [7:0]  v;
  int          mismatches;
  int          cmp_count;
  integer      seed = 32'h6d9a;

  timer16_top u_timer16_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ext_count_pin(ext_pin),
    .lp_osc_clk(lp_clk), .sysclk_from_lp_osc(sys_lp), .xtal_in_pin(xin),
    .xtal_out_pin(xout), .compare_trigger(trig), .lp_osc_enable(osc_en),
    .overflow_irq(irq), .xtal_pins_out(pins_out), .xtal_pins_oe(pins_oe));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // one whole-word transfer; entered just after a rising edge, waits on hready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] r);
    // no local limit: only the watchdog may end a wait
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hsize  <= 3'h2;
    haddr  <= {24'h00_0000, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h00_0000, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata[7:0];
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    xfer(1'b1, a, d, r);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string msg);
    logic [7:0] r;
    xfer(1'b0, a, 8'h00, r);
    chk({8'h00, r}, {8'h00, exp}, msg);
  endtask

  // sets both count bytes with the counter stopped, in narrow mode
  task automatic load(input logic [15:0] c);
    wr(`OFF_CONTROL, 8'h00);
    wr(`OFF_COUNT_HIGH, c[15:8]);
    wr(`OFF_COUNT_LOW, c[7:0]);
  endtask

  // three cycles high, three low: slow enough for the two-flop synchroniser
  task automatic pulses(input int n, input logic osc);
    repeat (n) begin
      if (osc) lp_clk <= 1'b1;
      else ext_pin <= 1'b1;
      repeat (3) @(posedge hclk);
      if (osc) lp_clk <= 1'b0;
      else ext_pin <= 1'b0;
      repeat (3) @(posedge hclk);
    end
    repeat (8) @(posedge hclk);
  endtask

  function automatic logic [7:0] ctl_exp(input logic [7:0] w, input logic s);
    return (w & `CONTROL_WMASK) | {1'b0, s, 6'h00};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    timer_control_t c;
    int cnt;
    {hsel, hwrite, ext_pin, lp_clk, sys_lp, xin, xout, trig} = '0;
    htrans = 2'h0;
    hsize = 3'h0;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    hresetn = 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // reset state of registers and outputs
    chk({osc_en, irq, pins_oe, pins_out}, 16'h0000, "outputs at reset");
    rdc(`OFF_CONTROL, 8'h00, "control reset");
    rdc(`OFF_COUNT_LOW, 8'h00, "low reset");
    rdc(`OFF_COUNT_HIGH, 8'h00, "high reset");
    rdc(`OFF_STATUS, 8'h00, "status reset");
    // random control values; bit 6 is read-only status
    for (int i = 0; i < 6; i++) begin
      v = 8'($random(seed));
      sys_lp <= v[0];
      wr(`OFF_CONTROL, v);
      repeat (4) @(posedge hclk);
      rdc(`OFF_CONTROL, ctl_exp(v, v[0]), "control readback");
      chk({15'h0000, osc_en}, {15'h0000, v[3]}, "osc enable out");
    end
    sys_lp <= 1'b0;
    // stopped counter holds, narrow bytes independent
    for (int i = 0; i < 4; i++) begin
      v = 8'($random(seed));
      load({v, ~v});
      repeat (20) @(posedge hclk);
      rdc(`OFF_COUNT_LOW, ~v, "held low");
      rdc(`OFF_COUNT_HIGH, v, "narrow high");
    end
    // internal source at each prescale code
    for (int ps = 0; ps < 4; ps++) begin
      load(16'h0000);
      c = '0;
      c.prescale_select = ps[1:0];
      c.count_on = 1'b1;
      c.no_sync_select = ps[0];
      wr(`OFF_CONTROL, c);
      repeat (256) @(posedge hclk);
      wr(`OFF_CONTROL, 8'h00);
      xfer(1'b0, `OFF_COUNT_LOW, 8'h00, rd);
      cnt = 64 >> ps;
      chk({15'h0000, (rd >= cnt - 1 && rd <= cnt + 1)}, 16'h0001, "prescaled rate");
    end
    // wide mode: buffered high byte
    load(16'h1111);
    wr(`OFF_CONTROL, 8'h80);
    wr(`OFF_COUNT_HIGH, 8'ha5);
    rdc(`OFF_COUNT_HIGH, 8'ha5, "buffer read");
    wr(`OFF_CONTROL, 8'h00);
    rdc(`OFF_COUNT_HIGH, 8'h11, "live high untouched");
    wr(`OFF_CONTROL, 8'h80);
    wr(`OFF_COUNT_LOW, 8'h3c);
    wr(`OFF_CONTROL, 8'h00);
    rdc(`OFF_COUNT_HIGH, 8'ha5, "wide load high");
    rdc(`OFF_COUNT_LOW, 8'h3c, "wide load low");
    wr(`OFF_COUNT_HIGH, 8'h5a);
    wr(`OFF_CONTROL, 8'h80);
    rdc(`OFF_COUNT_LOW, 8'h3c, "wide low read");
    rdc(`OFF_COUNT_HIGH, 8'h5a, "low read latches high");
    // overflow, flag, interrupt enable and clear
    load(16'hfffe);
    wr(`OFF_STATUS, 8'h02);
    wr(`OFF_CONTROL, 8'h01);
    repeat (24) @(posedge hclk);
    wr(`OFF_CONTROL, 8'h00);
    rdc(`OFF_COUNT_HIGH, 8'h00, "wrapped high");
    rdc(`OFF_STATUS, 8'h03, "overflow flag");
    chk({15'h0000, irq}, 16'h0001, "irq raised");
    wr(`OFF_STATUS, 8'h03);
    repeat (3) @(posedge hclk);
    chk({15'h0000, irq}, 16'h0000, "irq cleared");
    // compare trigger clears a synced count without setting the flag
    load(16'h4321);
    trig <= 1'b1;
    @(posedge hclk);
    trig <= 1'b0;
    @(posedge hclk);
    rdc(`OFF_COUNT_LOW, 8'h00, "trigger reset");
    rdc(`OFF_STATUS, 8'h02, "trigger no flag");
    // trigger held across a low write: the write must land
    trig <= 1'b1;
    wr(`OFF_COUNT_LOW, 8'h77);
    trig <= 1'b0;
    rdc(`OFF_COUNT_LOW, 8'h77, "write beats trigger");
    wr(`OFF_STATUS, 8'h00);
    load(16'h4321);
    wr(`OFF_CONTROL, 8'h06);
    trig <= 1'b1;
    @(posedge hclk);
    trig <= 1'b0;
    @(posedge hclk);
    rdc(`OFF_COUNT_LOW, 8'h21, "trigger ignored async");
    // external pin: first rise after enable is not counted
    load(16'h0000);
    wr(`OFF_CONTROL, 8'h03);
    pulses(5, 1'b0);
    rdc(`OFF_COUNT_LOW, 8'h04, "pin edges");
    // oscillator source; pin ignored, port logic off
    wr(`OFF_CONTROL, 8'h0b);
    wr(`OFF_COUNT_HIGH, 8'h00);
    wr(`OFF_COUNT_LOW, 8'h00);
    pulses(3, 1'b1);
    pulses(2, 1'b0);
    rdc(`OFF_COUNT_LOW, 8'h02, "osc edges");
    xin <= 1'b1;
    xout <= 1'b1;
    wr(`OFF_PORT, 8'h0f);
    repeat (4) @(posedge hclk);
    // pin levels read zero, stored out and dir bits stay readable
    rdc(`OFF_PORT, 8'h0f, "port with osc");
    chk({12'h000, pins_oe, pins_out}, 16'h0000, "pins off with osc");
    wr(`OFF_CONTROL, 8'h00);
    repeat (4) @(posedge hclk);
    rdc(`OFF_PORT, 8'h3f, "port without osc");
    chk({15'h0000, osc_en}, 16'h0000, "osc disabled");
    chk({12'h000, pins_oe, pins_out}, 16'h000f, "pins driven without osc");
    // reset in mid-run returns registers and pins to zero
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(`OFF_COUNT_LOW, 8'h00, "count after reset");
    rdc(`OFF_PORT, 8'h30, "port after reset");
    chk({12'h000, pins_oe, pins_out}, 16'h0000, "pins after reset");
    // unmapped place reads zero, write ignored
    wr(8'h20, 8'hff);
    rdc(8'h20, 8'h00, "unmapped");
    chk({15'h0000, hresp}, 16'h0000, "okay response");
    wrap_up();
  end

  // about 1540 cycles are needed; a hang is cut well beyond that
  initial begin
    repeat (40000) @(posedge hclk);
    mismatches++;
    $display("unexpected at %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule // timer16_with_buffered_access_tb_top
